// *** hw/ivm_pkg.sv ***
package ivm_pkg;
	// table geometry
	localparam int IVM_NUM_LINES = 25; // request lines 0..24
	localparam logic [23:0] IVM_VEC_BASE = 24'h008000; // reset vector slot
	localparam logic [23:0] IVM_VEC_TRAP = 24'h008004; // software trap slot
	localparam logic [23:0] IVM_VEC_LINE0 = 24'h008008; // first request line slot
	localparam logic [23:0] IVM_SLOT_BYTES = 24'h000004; // spacing between slots
	// documented slot addresses, used by the checks
	localparam logic [23:0] IVM_VEC_AWU = 24'h00800C;
	localparam logic [23:0] IVM_VEC_PA = 24'h008014;
	localparam logic [23:0] IVM_VEC_PB = 24'h008018;
	localparam logic [23:0] IVM_VEC_PC = 24'h00801C;
	localparam logic [23:0] IVM_VEC_PD = 24'h008020;
	localparam logic [23:0] IVM_VEC_PE = 24'h008024;
	localparam logic [23:0] IVM_VEC_RXF = 24'h008050;
	localparam logic [23:0] IVM_VEC_ADC = 24'h008060;
	// line numbers
	localparam int IVM_LN_TOP = 0;
	localparam int IVM_LN_AWU = 1;
	localparam int IVM_LN_PA = 3;
	localparam int IVM_LN_PB = 4;
	localparam int IVM_LN_PC = 5;
	localparam int IVM_LN_PD = 6;
	localparam int IVM_LN_PE = 7;
	localparam int IVM_LN_SPI = 10;
	localparam int IVM_LN_RXF = 18;
	localparam int IVM_LN_I2C = 19;
	localparam int IVM_LN_ADC = 22;
	localparam int IVM_PORT_PINS = 8; // pins per port
	localparam int IVM_PA_NOWAKE_PIN = 1; // port A pin one cannot wake
	// wake capability masks per line (bit n = line n)
	localparam logic [24:0] IVM_WAKE_HALT_MASK = 25'h00804F8; // lines 3..7, 10, 19
	localparam logic [24:0] IVM_WAKE_AHALT_MASK = 25'h00804FA;
	// service states, one-hot
	typedef enum logic [2:0] {
		IVM_ST_IDLE = 3'h1,
		IVM_ST_PRESENT = 3'h2,
		IVM_ST_WAIT = 3'h4
	} ivm_state_t;
endpackage : ivm_pkg

// *** hw/ivm_vector_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
// vector address lookup, registered output
module ivm_vector_rom
	import ivm_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [4:0] line_i, // line to look up
	output logic [23:0] addr_o // slot address, one cycle later
);
	// address = first slot + line * slot size, kept in a register
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			addr_o <= IVM_VEC_BASE;
		end else begin
			addr_o <= IVM_VEC_LINE0 + ({19'h0, line_i} * IVM_SLOT_BYTES);
		end
	end
endmodule : ivm_vector_rom
`default_nettype wire

// *** hw/ivm_interrupt_vector_map.sv ***
// Overview of operation
// - reset, trap, then lines in 4-byte slots
// - wakeup unit line 1, active-halt wake only
// - port A line 3, wakes except pin one
// - port B line 4, wakes both modes
// - port C line 5, wakes both modes
// - port D line 6, wakes both modes
// - port E line 7, wakes both modes
// - serial receive full line 18, no wake
// - converter done/watchdog merged line 22, no wake
`timescale 1ns/1ps
`default_nettype none
module ivm_interrupt_vector_map
	import ivm_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic top_level_ext_request_i, // line 0 level
	input wire logic auto_wakeup_unit_i, // line 1 level
	input wire logic clock_ctrl_req_i, // line 2 level
	input wire logic [7:0] port_a_pin_request_i, // per-pin levels
	input wire logic [7:0] port_b_pin_request_i,
	input wire logic [7:0] port_c_pin_request_i,
	input wire logic [7:0] port_d_pin_request_i,
	input wire logic [7:0] port_e_pin_request_i,
	input wire logic [24:0] other_req_i, // remaining lines, bits used per table
	input wire logic async_serial_port_rx_full_i, // line 18
	input wire logic analog_converter_eoc_i, // line 22 source a
	input wire logic analog_converter_awd_i, // line 22 source b
	input wire logic [24:0] line_enable_i, // per-line enable from core
	input wire logic trap_i, // software trap request
	input wire logic halt_i, // core in full halt
	input wire logic active_halt_i, // core in active-halt
	input wire logic ack_i, // core took the presented vector
	output logic irq_o, // vector valid to core
	output logic [23:0] vector_o, // slot address
	output logic [4:0] line_o, // line being served
	output logic wake_o // wake request toward power control
);
	logic [24:0] req; // merged per-line levels
	logic [24:0] pend; // enabled pending lines
	logic [4:0] pick; // lowest pending line
	logic any_pend;
	logic port_a_wake; // port A pins able to wake
	logic [4:0] line_r;
	logic irq_r;
	logic trap_r;
	logic wake_r;
	logic [23:0] rom_addr; // slot of the line picked one edge ago
	ivm_state_t state_r;
	ivm_state_t state_nxt;

	// port A pin one is left out of the wake path
	always_comb begin
		port_a_wake = 1'b0;
		for (int i = 0; i < IVM_PORT_PINS; i++) begin
			if (i != IVM_PA_NOWAKE_PIN) begin
				port_a_wake = port_a_wake | port_a_pin_request_i[i];
			end
		end
	end

	// gather sources onto their lines
	always_comb begin
		req = other_req_i;
		req[IVM_LN_TOP] = top_level_ext_request_i;
		req[IVM_LN_AWU] = auto_wakeup_unit_i;
		req[2] = clock_ctrl_req_i;
		req[IVM_LN_PA] = |port_a_pin_request_i;
		req[IVM_LN_PB] = |port_b_pin_request_i;
		req[IVM_LN_PC] = |port_c_pin_request_i;
		req[IVM_LN_PD] = |port_d_pin_request_i;
		req[IVM_LN_PE] = |port_e_pin_request_i;
		req[IVM_LN_RXF] = async_serial_port_rx_full_i;
		req[IVM_LN_ADC] = analog_converter_eoc_i | analog_converter_awd_i;
		pend = req & line_enable_i;
	end

	// priority pick: scan from the top so the lowest index wins
	always_comb begin
		pick = 5'h00;
		any_pend = |pend;
		for (int i = IVM_NUM_LINES - 1; i >= 0; i--) begin
			if (pend[i]) begin
				pick = 5'(i);
			end
		end
	end

	ivm_vector_rom u_rom (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.line_i(pick),
		.addr_o(rom_addr)
	);

	// service sequence: pick, present, wait for ack
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			IVM_ST_IDLE: begin
				if (trap_i || any_pend) begin
					state_nxt = IVM_ST_PRESENT;
				end
			end
			IVM_ST_PRESENT: begin
				state_nxt = IVM_ST_WAIT; // rom output now settled
			end
			IVM_ST_WAIT: begin
				if (ack_i) begin
					state_nxt = IVM_ST_IDLE;
				end
			end
			default: begin
				state_nxt = IVM_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_r <= IVM_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// latch the chosen line; trap is taken ahead of lines
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			line_r <= 5'h00;
			trap_r <= 1'b0;
		end else if (state_r == IVM_ST_IDLE) begin
			line_r <= pick;
			trap_r <= trap_i;
		end
	end

	// vector out: the lookup registered pick at the take edge, as line_r did,
	// so its slot matches the latched line even if pick moves afterwards
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			vector_o <= IVM_VEC_BASE;
			irq_r <= 1'b0;
		end else if (state_r == IVM_ST_PRESENT) begin
			// a trap takes its own slot ahead of any line
			vector_o <= trap_r ? IVM_VEC_TRAP : rom_addr;
			irq_r <= 1'b1;
		end else if (state_r == IVM_ST_WAIT && ack_i) begin
			irq_r <= 1'b0;
		end
	end

	// wake: halt honours halt mask, active-halt its own mask
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= (halt_i && (|(pend & IVM_WAKE_HALT_MASK & ~25'(1 << IVM_LN_PA))
				|| (line_enable_i[IVM_LN_PA] && port_a_wake)))
				|| (active_halt_i && (|(pend & IVM_WAKE_AHALT_MASK & ~25'(1 << IVM_LN_PA))
				|| (line_enable_i[IVM_LN_PA] && port_a_wake)));
		end
	end

	assign irq_o = irq_r;
	assign line_o = line_r;
	assign wake_o = wake_r;

	// vector being presented for a line, not for the trap
	sequence present_s;
		state_r == IVM_ST_PRESENT && !trap_r;
	endsequence
	// a take edge: idle, a line pending and no trap beside it
	sequence take_s;
		state_r == IVM_ST_IDLE && any_pend && !trap_i;
	endsequence
	// two edges after the take the line's vector is up
	sequence answer_s;
		##2 (irq_o && !trap_r);
	endsequence

	vec_slot_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		present_s |=> vector_o == IVM_VEC_LINE0 + {17'h0, $past(line_r), 2'h0})
		else $error("vector not in line slot");
	trap_slot_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		state_r == IVM_ST_PRESENT && trap_r |=> vector_o == IVM_VEC_TRAP)
		else $error("trap vector wrong");
	serve_time_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		take_s |-> answer_s)
		else $error("line vector late");
	// the core may sample late, so the vector must not move before its accept
	vec_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		irq_o && !ack_i |=> irq_o && $stable(vector_o))
		else $error("vector moved before accept");
	rom_agree_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$past(rst_b_i) && $past(pick) == 5'(IVM_LN_AWU) |-> rom_addr == IVM_VEC_AWU)
		else $error("rom lookup wrong");
	awu_no_halt_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		halt_i && !active_halt_i && pend == 25'(1 << IVM_LN_AWU) |=> !wake_o)
		else $error("wakeup unit woke full halt");
	pa_one_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		halt_i && pend == 25'(1 << IVM_LN_PA) && port_a_pin_request_i == 8'h02 |=> !wake_o)
		else $error("port A pin one woke");
	pb_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		halt_i && pend[IVM_LN_PB] |=> wake_o)
		else $error("port B no wake");
	pc_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		active_halt_i && pend[IVM_LN_PC] |=> wake_o)
		else $error("port C no wake");
	pd_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		halt_i && pend[IVM_LN_PD] |=> wake_o)
		else $error("port D no wake");
	pe_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		active_halt_i && pend[IVM_LN_PE] |=> wake_o)
		else $error("port E no wake");
	rx_no_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pend == 25'(1 << IVM_LN_RXF) |=> !wake_o)
		else $error("serial receive woke");
	adc_no_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pend == 25'(1 << IVM_LN_ADC) |=> !wake_o)
		else $error("converter woke");
	// latched line was pending and no lower line was
	low_first_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		take_s |=> ((($past(pend) >> line_r) & 25'h1) == 25'h1)
		&& (($past(pend) & ((25'h1 << line_r) - 25'h1)) == 25'h0))
		else $error("lower line skipped");
endmodule : ivm_interrupt_vector_map
`default_nettype wire

// *** tb/ivm_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// core side: accepts a presented vector after a chosen wait
module ivm_core_model (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic irq_i, // vector valid from the map
	input wire logic [3:0] delay_i, // cycles to wait before accepting
	output logic ack_o // one-cycle accept
);
	logic [3:0] cnt_r; // cycles waited so far
	logic busy_r; // accepted, waiting for irq to drop
	// falling edge, so the map samples a settled accept
	always_ff @(negedge mclk_i) begin
		if (!rst_b_i) begin
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			ack_o <= 1'b0;
		end else if (ack_o) begin
			ack_o <= 1'b0;
			busy_r <= 1'b1;
		end else if (!irq_i) begin
			busy_r <= 1'b0; // vector withdrawn, ready for the next one
			cnt_r <= 4'h0;
		end else if (!busy_r && cnt_r == delay_i) begin
			ack_o <= 1'b1;
			cnt_r <= 4'h0;
		end else if (!busy_r) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule : ivm_core_model
`default_nettype wire

// *** tb/interrupt_vector_map_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_map_bench
	import ivm_pkg::*;
;
	typedef struct {int ln; logic [1:0] w; logic [23:0] v;} ivm_row_t; // line, wake, slot
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [24:0] lv = '0; // request level per line
	logic pa1 = 1'b0, awd = 1'b0, trap = 1'b0, halt = 1'b0, ahalt = 1'b0;
	logic [3:0] dly = 4'h0; // core accept delay
	logic [24:0] en = 25'h1FFFFFF; // per-line enables
	logic ack, irq, wake;
	logic [23:0] vec;
	logic [4:0] ln;
	int error_cnt = 0, comparisons = 0;
	// plain cases: one source each
	ivm_row_t rows[9] = '{'{0, 2'h0, IVM_VEC_LINE0}, '{1, 2'h2, IVM_VEC_AWU},
		'{3, 2'h3, IVM_VEC_PA}, '{4, 2'h3, IVM_VEC_PB}, '{5, 2'h3, IVM_VEC_PC},
		'{6, 2'h3, IVM_VEC_PD}, '{7, 2'h3, IVM_VEC_PE}, '{18, 2'h0, IVM_VEC_RXF},
		'{22, 2'h0, IVM_VEC_ADC}};
	// clock, 10 ns period
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	ivm_interrupt_vector_map dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.top_level_ext_request_i(lv[0]), .auto_wakeup_unit_i(lv[1]), .clock_ctrl_req_i(lv[2]),
		.port_a_pin_request_i({6'h00, pa1, lv[3]}), .port_b_pin_request_i({7'h00, lv[4]}),
		.port_c_pin_request_i({7'h00, lv[5]}), .port_d_pin_request_i({7'h00, lv[6]}),
		.port_e_pin_request_i({7'h00, lv[7]}), .other_req_i(lv),
		.async_serial_port_rx_full_i(lv[18]), .analog_converter_eoc_i(lv[22]),
		.analog_converter_awd_i(awd), .line_enable_i(en), .trap_i(trap),
		.halt_i(halt), .active_halt_i(ahalt), .ack_i(ack), .irq_o(irq), .vector_o(vec),
		.line_o(ln), .wake_o(wake));
	ivm_core_model core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .irq_i(irq), .delay_i(dly),
		.ack_o(ack));
	task automatic chk_v(input logic [23:0] a, input logic [23:0] e);
		comparisons++;
		if (a !== e) begin
			error_cnt++;
			$display("wrong value at %0t: word %h expected %h", $time, a, e);
		end
	endtask : chk_v
	task automatic chk_b(input logic a, input logic e);
		comparisons++;
		if (a !== e) begin
			error_cnt++;
			$display("wrong value at %0t: flag %b expected %b", $time, a, e);
		end
	endtask : chk_b
	task automatic tally_and_finish();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// request already raised: check wake, vector, line, then withdraw all
	task automatic run(input logic ew, input logic [23:0] ev, input int el, input logic cl);
		int k;
		@(negedge mclk_i);
		@(negedge mclk_i);
		chk_b(wake, ew);
		for (k = 0; k < 20 && irq !== 1'b1; k++) begin
			@(negedge mclk_i);
		end
		chk_b(irq, 1'b1);
		chk_v(vec, ev);
		if (cl) begin
			chk_v({19'h0, ln}, 24'(el));
		end
		lv = '0;
		pa1 = 1'b0;
		awd = 1'b0;
		trap = 1'b0;
		// bounded wait for the core's accept to drop irq
		for (k = 0; k < 20 && irq !== 1'b0; k++) begin
			@(negedge mclk_i);
		end
		chk_b(irq, 1'b0);
		@(negedge mclk_i);
	endtask : run
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(negedge mclk_i);
		rst_b_i = 1'b1;
		chk_v(vec, IVM_VEC_BASE);
		chk_b(irq, 1'b0);
		// each row in full halt (prompt core) and active-halt (slow core)
		foreach (rows[i]) begin
			for (int m = 0; m < 2; m++) begin
				halt = (m == 0);
				ahalt = (m == 1);
				dly = (m == 1) ? 4'h5 : 4'h0;
				lv[rows[i].ln] = 1'b1;
				run(rows[i].w[m], rows[i].v, rows[i].ln,
					1'b1);
			end
		end
		// two ports at once in halt: lower line first
		halt = 1'b1;
		ahalt = 1'b0;
		lv[7] = 1'b1;
		lv[4] = 1'b1;
		run(1'b1, IVM_VEC_PB, IVM_LN_PB, 1'b1);
		// a disabled line is passed over for the next enabled one
		en[IVM_LN_PB] = 1'b0;
		lv[4] = 1'b1;
		lv[7] = 1'b1;
		run(1'b1, IVM_VEC_PE, IVM_LN_PE, 1'b1);
		en = 25'h1FFFFFF;
		// port A pin one alone cannot wake
		pa1 = 1'b1;
		run(1'b0, IVM_VEC_PA, IVM_LN_PA, 1'b1);
		// watchdog source of the converter shares line 22, no wake
		halt = 1'b0;
		ahalt = 1'b1;
		awd = 1'b1;
		run(1'b0, IVM_VEC_ADC, IVM_LN_ADC, 1'b1);
		// trap with a line pending takes the trap slot
		ahalt = 1'b0;
		trap = 1'b1;
		lv[5] = 1'b1;
		run(1'b0, IVM_VEC_TRAP, 0, 1'b0);
		// reset in mid-service, core held off so the vector stands
		dly = 4'hF;
		halt = 1'b1;
		lv[6] = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk_b(irq, 1'b1);
		rst_b_i = 1'b0;
		lv = '0;
		halt = 1'b0;
		@(negedge mclk_i);
		chk_b(irq, 1'b0);
		chk_v(vec, IVM_VEC_BASE);
		chk_v({19'h0, ln}, 24'h000000);
		chk_b(wake, 1'b0);
		rst_b_i = 1'b1;
		// first request right at release
		dly = 4'h0;
		ahalt = 1'b1;
		lv[1] = 1'b1;
		run(1'b1, IVM_VEC_AWU, IVM_LN_AWU, 1'b1);
		tally_and_finish();
	end
endmodule : interrupt_vector_map_bench
`default_nettype wire
